// ### hw/dmx_pkg.sv
// shared constants, types and opcode decode for the data-move execution block
package dmx_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR  = 8'h04;
  localparam logic [7:0] OFS_WORK   = 8'h08;
  localparam logic [7:0] OFS_BANK   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INDEX  = 8'h14;
  // field positions
  localparam int CTRL_EXT_EN = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_WAIT2    = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_NEG      = 3;
  localparam int ST_BAD      = 4;
  // reset values
  localparam logic        RST_EXT_EN = 1'b0;
  localparam logic [7:0]  RST_WORK   = 8'h00;
  localparam logic [7:0]  RST_BANK   = 8'h00;
  localparam logic [11:0] RST_INDEX  = 12'h000;
  // addressing constants
  localparam logic [7:0]  IDX_LIMIT  = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  ACC_HIGH   = 4'hF;
  localparam logic [3:0]  ACC_LOW    = 4'h0;
  localparam logic [11:0] WORK_ADDR  = 12'hFE0;
  // opcode prefixes
  localparam logic [5:0]  PFX_FILE_TO_DEST = 6'h14;
  localparam logic [3:0]  PFX_FF_SRC       = 4'hC;
  localparam logic [3:0]  PFX_FF_DST       = 4'hF;
  localparam logic [7:0]  PFX_BANK_LIT     = 8'h01;
  localparam logic [7:0]  PFX_WORK_LIT     = 8'h0E;
  localparam logic [6:0]  PFX_WORK_TO_FILE = 7'h37;

  // instruction phases, gray from idle to write; the step from write back to idle changes two bits
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DECODE  = 3'b001,
    PH_READ    = 3'b011,
    PH_PROCESS = 3'b010,
    PH_WRITE   = 3'b110
  } dmx_phase_type;

  // decoded operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_MOVE_FILE_TO_DEST,
    OP_FILE_TO_FILE_SRC,
    OP_FILE_TO_FILE_DST,
    OP_LOAD_BANK_SELECT_LITERAL,
    OP_LOAD_LITERAL_TO_WORK,
    OP_MOVE_WORK_TO_FILE
  } dmx_op_type;

  // classify one program word
  function automatic dmx_op_type dmx_decode(input logic [15:0] word);
    dmx_op_type op;
    op = OP_NONE;
    if (word[15:10] == PFX_FILE_TO_DEST)
      op = OP_MOVE_FILE_TO_DEST;
    else if (word[15:12] == PFX_FF_SRC)
      op = OP_FILE_TO_FILE_SRC;
    else if (word[15:12] == PFX_FF_DST)
      op = OP_FILE_TO_FILE_DST;
    else if (word[15:8] == PFX_BANK_LIT)
      op = OP_LOAD_BANK_SELECT_LITERAL;
    else if (word[15:8] == PFX_WORK_LIT)
      op = OP_LOAD_LITERAL_TO_WORK;
    else if (word[15:9] == PFX_WORK_TO_FILE)
      op = OP_MOVE_WORK_TO_FILE;
    return op;
  endfunction
endpackage

// ### hw/dmx_core_if.sv
// internal carrier between the executor, its address resolver and phase sequencer
interface dmx_core_if;
  logic [7:0]            file_sel;
  logic                  access_sel;
  logic                  ext_en;
  logic [3:0]            bank;
  logic [11:0]           index_base;
  logic [11:0]           addr;
  logic                  start;
  dmx_pkg::dmx_phase_type phase;

  modport resolver (input file_sel, access_sel, ext_en, bank, index_base, output addr);
  modport sequencer (input start, output phase);
  modport core (output file_sel, access_sel, ext_en, bank, index_base, start, input addr, phase);
endinterface

// ### hw/dmx_addr_resolve.sv
// turns an 8-bit file operand into a 12-bit data-space address
module dmx_addr_resolve (
  dmx_core_if.resolver rif
);
  // indexed literal offset, access bank or banked operand
  always_comb
  begin
    if (!rif.access_sel && rif.ext_en && rif.file_sel <= dmx_pkg::IDX_LIMIT)
    begin
      rif.addr = 12'(rif.index_base + {4'h0, rif.file_sel});
    end
    else if (!rif.access_sel)
      rif.addr = (rif.file_sel < dmx_pkg::ACC_SPLIT) ? {dmx_pkg::ACC_LOW, rif.file_sel}
                                                     : {dmx_pkg::ACC_HIGH, rif.file_sel};
    else
      rif.addr = {rif.bank, rif.file_sel};
  end
endmodule

// ### hw/dmx_phase_seq.sv
// steps one instruction cycle through its four phases
module dmx_phase_seq (
  input  wire logic    pclk,
  input  wire logic    presetn,
  dmx_core_if.sequencer sif
);
  typedef struct packed {
    dmx_pkg::dmx_phase_type phase;
  } dmx_seq_state_type;

  dmx_seq_state_type s_reg;
  dmx_seq_state_type s_next;

  // decode, read, process, write, then back to idle
  always_comb
  begin
    s_next = s_reg;
    case (s_reg.phase)
      dmx_pkg::PH_IDLE:    s_next.phase = sif.start ? dmx_pkg::PH_DECODE : dmx_pkg::PH_IDLE;
      dmx_pkg::PH_DECODE:  s_next.phase = dmx_pkg::PH_READ;
      dmx_pkg::PH_READ:    s_next.phase = dmx_pkg::PH_PROCESS;
      dmx_pkg::PH_PROCESS: s_next.phase = dmx_pkg::PH_WRITE;
      default:             s_next.phase = dmx_pkg::PH_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '{phase: dmx_pkg::PH_IDLE};
    else
      s_reg <= s_next;
  end

  assign sif.phase = s_reg.phase;
endmodule

// ### hw/dmx_exec.sv
// data-move instruction executor with its bus register file
module dmx_exec (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // data memory and special registers
  output logic [11:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr_en,
  output logic [7:0]       mem_wdata
);
  typedef struct packed {
    // software-visible registers
    logic                   ext_en;
    logic [7:0]             work;
    logic [7:0]             bank;
    logic [11:0]            index_base;
    // status flags
    logic                   neg;
    logic                   zero;
    logic                   bad;
    // instruction in flight
    logic [15:0]            instr;
    logic                   start;
    logic                   busy;
    logic                   wait2;
    dmx_pkg::dmx_op_type    op;
    logic [11:0]            target;
    logic [7:0]             data;
    // memory port
    logic [11:0]            mem_addr;
    logic [7:0]             mem_wdata;
    logic                   mem_re;
    logic                   mem_we;
    // bus answer
    logic                   ack;
    logic [31:0]            prdata;
    logic                   pslverr;
  } dmx_exec_state_type;

  // registered state and its next value
  dmx_exec_state_type s_reg;
  dmx_exec_state_type s_next;
  // carrier toward the resolver and the sequencer
  dmx_core_if         cif ();
  // bus decode results
  dmx_pkg::dmx_op_type new_op;
  logic               hit;
  logic               refuse;
  logic               word_ok;
  logic               commit;
  logic [31:0]        rd_val;

  // the work register has a data-space address but lives in this block
  function automatic logic is_work_addr(input logic [11:0] addr);
    return addr == dmx_pkg::WORK_ADDR;
  endfunction

  // both words of the file-to-file move carry a full 12-bit address
  function automatic logic is_pair_op(input dmx_pkg::dmx_op_type op);
    return (op == dmx_pkg::OP_FILE_TO_FILE_SRC) || (op == dmx_pkg::OP_FILE_TO_FILE_DST);
  endfunction

  // operations that fetch their operand through the memory port
  function automatic logic reads_memory(input dmx_pkg::dmx_op_type op, input logic [11:0] addr);
    return (op == dmx_pkg::OP_MOVE_FILE_TO_DEST) || (op == dmx_pkg::OP_FILE_TO_FILE_SRC && !is_work_addr(addr));
  endfunction

  // status flags packed into one bus word
  function automatic logic [31:0] status_word(input dmx_exec_state_type st);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[dmx_pkg::ST_BUSY]  = st.busy;
    w[dmx_pkg::ST_WAIT2] = st.wait2;
    w[dmx_pkg::ST_ZERO]  = st.zero;
    w[dmx_pkg::ST_NEG]   = st.neg;
    w[dmx_pkg::ST_BAD]   = st.bad;
    return w;
  endfunction

  // operand address resolution
  dmx_addr_resolve u_resolve (
    .rif (cif.resolver)
  );

  // phase sequencer
  dmx_phase_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (cif.sequencer)
  );

  // operand fields toward the resolver
  // the resolver reads the stored word, so bus traffic cannot disturb a running move
  assign cif.file_sel   = s_reg.instr[7:0];
  assign cif.access_sel = s_reg.instr[8];
  assign cif.ext_en     = s_reg.ext_en;
  assign cif.bank       = s_reg.bank[3:0];
  assign cif.index_base = s_reg.index_base;
  assign cif.start      = s_reg.start;

  // address decode and read mux
  // an unmapped offset reads zero and raises the error flag
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      dmx_pkg::OFS_CTRL:   rd_val[dmx_pkg::CTRL_EXT_EN] = s_reg.ext_en;
      dmx_pkg::OFS_INSTR:  rd_val[15:0] = s_reg.instr;
      dmx_pkg::OFS_WORK:   rd_val[7:0] = s_reg.work;
      dmx_pkg::OFS_BANK:   rd_val[7:0] = s_reg.bank;
      dmx_pkg::OFS_INDEX:  rd_val[11:0] = s_reg.index_base;
      dmx_pkg::OFS_STATUS: rd_val = status_word(s_reg);
      default:             hit = 1'b0;
    endcase
  end

  // writes are refused at unmapped offsets and, except at the status offset, while an instruction runs
  assign refuse  = !hit || (pwrite && s_reg.busy && paddr != dmx_pkg::OFS_STATUS);
  // the incoming word is classified while it still stands on the bus
  assign new_op  = dmx_pkg::dmx_decode(pwdata[15:0]);
  // a second word must follow a pending first word and only then, and unknown words are refused
  assign word_ok = (s_reg.wait2 == (new_op == dmx_pkg::OP_FILE_TO_FILE_DST))
                && (new_op != dmx_pkg::OP_NONE);
  // a write lands at the edge that ends its ready cycle, unless it was refused when latched
  assign commit  = s_reg.ack && pwrite && !s_reg.pslverr;

  // bus slave and instruction execution
  // writes other than to status are refused while busy, so the bus and phase branches never touch one field in one cycle
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    // bus: first access cycle latches the answer, second completes it
    if (psel && penable && !s_reg.ack)
    begin
      // latch read data and the refusal, answer in the next cycle
      s_next.ack     = 1'b1;
      s_next.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      s_next.pslverr = refuse;
    end
    else if (s_reg.ack)
    begin
      // ready cycle: drop the answer and apply a write that was not refused
      s_next.ack     = 1'b0;
      s_next.pslverr = 1'b0;
      if (commit)
      begin
        // narrow registers keep only their low bits
        case (paddr)
          dmx_pkg::OFS_CTRL:  s_next.ext_en = pwdata[dmx_pkg::CTRL_EXT_EN];
          dmx_pkg::OFS_WORK:  s_next.work = pwdata[7:0];
          dmx_pkg::OFS_BANK:  s_next.bank = {4'h0, pwdata[3:0]};
          dmx_pkg::OFS_INDEX: s_next.index_base = pwdata[11:0];
          dmx_pkg::OFS_INSTR:
          begin
            // a misplaced or unknown word flags bad and drops any pending pair
            if (!word_ok)
            begin
              s_next.bad   = 1'b1;
              s_next.wait2 = 1'b0;
            end
            else
            begin
              // accept: latch the word and start its cycle
              s_next.instr = pwdata[15:0];
              s_next.start = 1'b1;
              s_next.busy  = 1'b1;
              s_next.bad   = 1'b0;
              s_next.wait2 = 1'b0;
            end
          end
          default: s_next.bad = s_reg.bad;
        endcase
      end
    end

    // instruction phases
    case (cif.phase)
      // decode: resolve the operand and ask memory for it when needed
      dmx_pkg::PH_DECODE:
      begin
        s_next.op     = dmx_pkg::dmx_decode(s_reg.instr);
        s_next.target = cif.addr;
        // pair words carry a full address and skip bank resolution
        if (is_pair_op(s_next.op))
          s_next.target = s_reg.instr[11:0];
        s_next.mem_addr = s_next.target;
        // fetch the operand for a move from file, and for a pair source unless it is the work register kept here
        s_next.mem_re = reads_memory(s_next.op, s_next.target);
      end
      // read: the strobe stands one cycle only
      dmx_pkg::PH_READ:
      begin
        s_next.mem_re = 1'b0;
      end
      // process: take the operand and line up the write
      dmx_pkg::PH_PROCESS:
      begin
        case (s_reg.op)
          // write back only when the direction bit asks for it
          dmx_pkg::OP_MOVE_FILE_TO_DEST:
          begin
            s_next.data = mem_rdata;
            s_next.mem_we = s_reg.instr[9];
          end
          dmx_pkg::OP_FILE_TO_FILE_SRC:
            s_next.data = is_work_addr(s_reg.target) ? s_reg.work : mem_rdata;
          dmx_pkg::OP_FILE_TO_FILE_DST:
            s_next.mem_we = !is_work_addr(s_reg.target);
          dmx_pkg::OP_MOVE_WORK_TO_FILE:
          begin
            s_next.data   = s_reg.work;
            s_next.mem_we = 1'b1;
          end
          default:
            s_next.data = s_reg.instr[7:0]; // literal operand
        endcase
        s_next.mem_wdata = s_next.data;
        s_next.mem_addr  = s_reg.target;
      end
      // write: land the result and free the instruction slot
      dmx_pkg::PH_WRITE:
      begin
        s_next.mem_we = 1'b0;
        s_next.busy   = 1'b0;
        case (s_reg.op)
          dmx_pkg::OP_MOVE_FILE_TO_DEST:
          begin
            if (!s_reg.instr[9])
              s_next.work = s_reg.data;
            s_next.neg  = s_reg.data[7];
            s_next.zero = (s_reg.data == 8'h00);
          end
          dmx_pkg::OP_FILE_TO_FILE_SRC:
            s_next.wait2 = 1'b1;
          // a work destination never reaches the memory port
          dmx_pkg::OP_FILE_TO_FILE_DST:
            if (is_work_addr(s_reg.target))
              s_next.work = s_reg.data;
          dmx_pkg::OP_LOAD_BANK_SELECT_LITERAL:
            s_next.bank = {4'h0, s_reg.data[3:0]};
          dmx_pkg::OP_LOAD_LITERAL_TO_WORK:
            s_next.work = s_reg.data;
          default:
            s_next.work = s_reg.work;
        endcase
      end
      // idle: keep the memory port quiet
      default:
      begin
        s_next.mem_we = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // constants only: clear every field, then load the reset values
      s_reg            <= '0;
      s_reg.ext_en     <= dmx_pkg::RST_EXT_EN;
      s_reg.work       <= dmx_pkg::RST_WORK;
      s_reg.bank       <= dmx_pkg::RST_BANK;
      s_reg.index_base <= dmx_pkg::RST_INDEX;
      s_reg.op         <= dmx_pkg::OP_NONE;
    end
    else
      s_reg <= s_next;
  end

  // outputs, each from a flip-flop except pslverr, an AND of two
  // pslverr is masked so it never stands without pready
  assign prdata    = s_reg.prdata;
  assign pready    = s_reg.ack;
  assign pslverr   = s_reg.ack & s_reg.pslverr;
  assign mem_addr  = s_reg.mem_addr;
  assign mem_rd_en = s_reg.mem_re;
  assign mem_wr_en = s_reg.mem_we;
  assign mem_wdata = s_reg.mem_wdata;
endmodule

// ### test/dmx_exec_asserts.sv
// port-level checks of the data-move executor
module dmx_exec_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory side
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        ext_q;
  logic [11:0] idx_q;
  logic        pend_q;
  logic        wr_ok;
  logic        iw;
  logic [11:0] exp_a;
  // accepted writes, and accepted program words among them
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign iw = wr_ok && paddr == dmx_pkg::OFS_INSTR;
  // expected target of move-work-to-file with access bit 0
  assign exp_a = pwdata[7:0] > dmx_pkg::IDX_LIMIT ? {4'hF, pwdata[7:0]}
               : ext_q ? idx_q + {4'h0, pwdata[7:0]} : {4'h0, pwdata[7:0]};
  // shadow of extension enable, index base and pending pair
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q <= 1'b0;
      idx_q <= 12'h000;
      pend_q <= 1'b0;
    end
    else
    begin
      if (wr_ok && paddr == dmx_pkg::OFS_CTRL)
        ext_q <= pwdata[0];
      if (wr_ok && paddr == dmx_pkg::OFS_INDEX)
        idx_q <= pwdata[11:0];
      if (iw)
        pend_q <= pwdata[15:12] == dmx_pkg::PFX_FF_SRC && !pend_q;
    end
  end
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
  chk_ready_once: assert property (pready |=> !pready) else $error("pready held");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_read_pulse: assert property (mem_rd_en |=> !mem_rd_en) else $error("read strobe held");
  chk_literal_quiet: assert property (iw && (pwdata[15:8] == dmx_pkg::PFX_WORK_LIT
    || pwdata[15:8] == dmx_pkg::PFX_BANK_LIT) |=> (!mem_rd_en && !mem_wr_en) [*6]) else $error("literal hit memory");
  chk_store_addr: assert property (iw && pwdata[15:9] == dmx_pkg::PFX_WORK_TO_FILE && !pwdata[8]
    |-> ##5 mem_wr_en && mem_addr == $past(exp_a, 5)) else $error("store address");
  chk_move_copy: assert property (iw && pwdata[15:9] == {dmx_pkg::PFX_FILE_TO_DEST, 1'b1} |-> ##3 mem_rd_en
    ##2 mem_wr_en && mem_addr == $past(mem_addr, 2) && mem_wdata == $past(mem_rdata)) else $error("move copy");
  chk_pair_src: assert property (iw && !pend_q && pwdata[15:12] == dmx_pkg::PFX_FF_SRC
    && pwdata[11:0] != dmx_pkg::WORK_ADDR |-> ##3 mem_rd_en && mem_addr == $past(pwdata[11:0], 3)) else $error("src");
  chk_pair_dst: assert property (iw && pend_q && pwdata[15:12] == dmx_pkg::PFX_FF_DST
    && pwdata[11:0] != dmx_pkg::WORK_ADDR |-> ##3 !mem_rd_en ##2 mem_wr_en && mem_addr == $past(pwdata[11:0], 5))
    else $error("dst");
  cover property (iw && pend_q);
  cover property (pslverr);
  cover property (mem_wr_en);
endmodule
bind dmx_exec dmx_exec_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata);

// ### test/dmx_mem_model.sv
// behavioural data memory answering one cycle after a read strobe
module dmx_mem_model (
  // clock
  input wire logic        pclk,
  // memory port
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  output logic [7:0]      mem_rdata,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] arr [4096];
  initial mem_rdata = 8'h5A;
  // read data stands one cycle, otherwise the bus keeps toggling
  always @(posedge pclk)
  begin
    mem_rdata <= mem_rd_en ? arr[mem_addr] : ~mem_rdata;
    if (mem_wr_en)
      arr[mem_addr] <= mem_wdata;
  end
endmodule

// ### test/tb_top.sv
// self-checking bench for the data-move executor
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin failures++; $display("BAD %s exp %h got %h", n, x, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] mem_addr;
  logic        mem_rd_en;
  logic [7:0]  mem_rdata;
  logic        mem_wr_en;
  logic [7:0]  mem_wdata;
  logic [31:0] r;
  logic        e;
  int          failures;
  int          check_count;
  logic [7:0]  offs [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0]  fo [3] = '{8'h05, 8'h5F, 8'h60};
  logic [11:0] fa [3] = '{12'h128, 12'h182, 12'hF60};
  localparam logic [31:0] SZ = 32'h1 << dmx_pkg::ST_ZERO;
  localparam logic [31:0] SN = 32'h1 << dmx_pkg::ST_NEG;
  localparam logic [31:0] SW = 32'h1 << dmx_pkg::ST_WAIT2;
  localparam logic [31:0] SB = 32'h1 << dmx_pkg::ST_BAD;
  dmx_exec uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata);
  dmx_mem_model mem (.pclk, .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata);
  // free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one bus transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  // issue one program word and let its cycle finish
  task automatic ins(input logic [15:0] w);
    apb(1'b1, dmx_pkg::OFS_INSTR, {16'h0000, w});
    repeat (6) @(posedge pclk);
  endtask
  // read a register and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, x, r)
  endtask
  // main sequence; no destination is the program counter or a stack byte
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    failures = 0;
    check_count = 0;
    mem.arr[12'h010] = 8'h00;
    mem.arr[12'h456] = 8'h3C;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    ins(16'h5010);
    rd(dmx_pkg::OFS_WORK, 32'h00, "move to work");
    rd(dmx_pkg::OFS_STATUS, SZ, "zero flag");
    ins(16'h0E80);
    rd(dmx_pkg::OFS_WORK, 32'h80, "literal");
    rd(dmx_pkg::OFS_STATUS, SZ, "literal flags");
    ins(16'h01F3);
    rd(dmx_pkg::OFS_BANK, 32'h03, "bank select");
    ins(16'h6F22);
    `CHK("banked store", 8'h80, mem.arr[12'h322])
    ins(16'h5322);
    rd(dmx_pkg::OFS_STATUS, SN, "neg flag");
    `CHK("write back", 8'h80, mem.arr[12'h322])
    apb(1'b1, dmx_pkg::OFS_INDEX, 32'h123);
    apb(1'b1, dmx_pkg::OFS_CTRL, 32'h1);
    foreach (fo[i])
    begin
      ins({8'h6E, fo[i]});
      `CHK("indexed store", 8'h80, mem.arr[fa[i]])
    end
    ins(16'hC456);
    rd(dmx_pkg::OFS_STATUS, SN | SW, "pair pending");
    ins(16'hF789);
    `CHK("pair copy", 8'h3C, mem.arr[12'h789])
    rd(dmx_pkg::OFS_STATUS, SN, "pair flags");
    ins(16'hCFE0);
    ins(16'hFABC);
    `CHK("work source", 8'h80, mem.arr[12'hABC])
    ins(16'hC456);
    ins(16'hFFE0);
    rd(dmx_pkg::OFS_WORK, 32'h3C, "work dest");
    ins(16'hF123);
    rd(dmx_pkg::OFS_STATUS, SN | SB, "lone second word");
    apb(1'b1, dmx_pkg::OFS_INSTR, 32'h0E11);
    apb(1'b1, dmx_pkg::OFS_WORK, 32'h55);
    `CHK("busy refusal", 1'b1, e)
    repeat (6) @(posedge pclk);
    rd(dmx_pkg::OFS_WORK, 32'h11, "busy work");
    rd(dmx_pkg::OFS_STATUS, SN, "bad cleared");
    tally_and_finish();
  end
endmodule
